/* File: hdl/kwd_pkg.sv */
// Package for the keyed watchdog timer: offsets, keys, fields, types
package kwd_pkg;

  // ----------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] OFS_MODE = 8'h00; // overflow_mode
  localparam logic [7:0] OFS_CLK = 8'h04; // clock_mode
  localparam logic [7:0] OFS_RESTART = 8'h08; // restart_control
  localparam logic [7:0] OFS_STATUS = 8'h0C; // overflow_status
  localparam logic [7:0] OFS_EVENT = 8'h10; // Sticky event status
  localparam logic [7:0] OFS_MASK = 8'h14; // Event mask

  // ----------------------------------------
  // Access keys
  // ----------------------------------------
  localparam logic [11:0] MODE_KEY = 12'h234; // mode_write_key
  localparam logic [8:0] CLK_KEY = 9'h06E; // clock_write_key
  localparam logic [15:0] RESTART_KEY = 16'hC071; // restart_key

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int EN_BIT = 0; // watchdog_enable
  localparam int RST_BIT = 1; // overflow_reset_enable
  localparam int IRQ_BIT = 2; // overflow_interrupt_enable
  localparam int PIN_BIT = 3; // pin_pulse_enable
  localparam int MODE_KEY_LSB = 4; // Key field, 12 bits
  localparam int SEL_LSB = 0; // count_clock_select, 2 bits
  localparam int HP_LSB = 2; // preload_high_nibble, 4 bits
  localparam int CLK_KEY_LSB = 7; // Key field, 9 bits
  localparam int EVT_OVF_BIT = 0; // Overflow event
  localparam int EVT_KEY_BIT = 1; // Rejected mode or clock keyed write

  // ----------------------------------------
  // Reset values and timing counts
  // ----------------------------------------
  localparam logic [3:0] MODE_RST = 4'h0;
  localparam logic [1:0] SEL_RST = 2'h0;
  localparam logic [3:0] HP_RST = 4'h0;
  localparam logic [1:0] EVT_RST = 2'h0;
  localparam logic [1:0] MASK_RST = 2'h0;
  localparam logic [11:0] PRELOAD_LOW = 12'hFFF; // Low bits on restart
  localparam logic [3:0] PIN_LOW_CYCLES = 4'h8; // Master clock cycles

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } kwd_bus_req_t;

  typedef struct packed {
    logic intReset; // watchdog_internal_reset pulse
    logic irqLine; // watchdog_interrupt_line pulse
    logic pinN; // overflow_pin_n, active low
  } kwd_ovf_out_t;

endpackage

/* File: hdl/kwd_keyed_watchdog.sv */
// Keyed watchdog timer: registers, prescaler, down counter, outputs
//
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/1ps
module kwd_keyed_watchdog (
  input wire logic clock,
  input wire logic rst,
  input wire kwd_pkg::kwd_bus_req_t busReq,
  output logic [31:0] rdData,
  output kwd_pkg::kwd_ovf_out_t ovfOut,
  output logic irq
);

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  wire hitMode = busReq.addr == kwd_pkg::OFS_MODE;
  wire hitClk = busReq.addr == kwd_pkg::OFS_CLK;
  wire hitRestart = busReq.addr == kwd_pkg::OFS_RESTART;
  wire hitStatus = busReq.addr == kwd_pkg::OFS_STATUS;
  wire hitEvent = busReq.addr == kwd_pkg::OFS_EVENT;
  wire hitMask = busReq.addr == kwd_pkg::OFS_MASK;

  // Key fields taken from this very write only
  wire [11:0] modeKey = busReq.wdata[kwd_pkg::MODE_KEY_LSB +: 12];
  wire [8:0] clkKey = busReq.wdata[kwd_pkg::CLK_KEY_LSB +: 9];
  wire modeKeyOk = modeKey == kwd_pkg::MODE_KEY;
  wire clkKeyOk = clkKey == kwd_pkg::CLK_KEY;

  // Write strobes per register
  wire wrMode = busReq.wr && hitMode;
  wire wrClk = busReq.wr && hitClk;
  wire wrEvent = busReq.wr && hitEvent;
  wire wrMask = busReq.wr && hitMask;

  // Accepted keyed updates
  wire modeUpd = wrMode && modeKeyOk;
  wire clkUpd = wrClk && clkKeyOk;

  // Rejected mode or clock keyed write, reported as an event; a wrong restart key is not
  wire keyReject = (wrMode && !modeKeyOk) || (wrClk && !clkKeyOk);

  // Restart only on the exact key value
  wire restart = busReq.wr && hitRestart &&
    (busReq.wdata[15:0] == kwd_pkg::RESTART_KEY);

  // ----------------------------------------
  // Mode and clock registers
  // ----------------------------------------
  logic [3:0] mode_q; // Enables, low nibble of overflow_mode
  logic [1:0] clkSel_q; // count_clock_select
  logic [3:0] preloadHigh_q; // preload_high_nibble

  // Named views of the mode bits
  wire wdEnable = mode_q[kwd_pkg::EN_BIT];
  wire rstEnable = mode_q[kwd_pkg::RST_BIT];
  wire irqEnable = mode_q[kwd_pkg::IRQ_BIT];
  wire pinEnable = mode_q[kwd_pkg::PIN_BIT];

  // Keyed mode register, cleared by reset
  always_ff @(posedge clock) begin
    if (rst) begin
      mode_q <= kwd_pkg::MODE_RST;
    end else if (modeUpd) begin
      mode_q <= busReq.wdata[3:0];
    end
  end

  // Keyed clock register, fastest tap after reset
  always_ff @(posedge clock) begin
    if (rst) begin
      clkSel_q <= kwd_pkg::SEL_RST;
      preloadHigh_q <= kwd_pkg::HP_RST;
    end else if (clkUpd) begin
      clkSel_q <= busReq.wdata[kwd_pkg::SEL_LSB +: 2];
      preloadHigh_q <= busReq.wdata[kwd_pkg::HP_LSB +: 4];
    end
  end

  // ----------------------------------------
  // Prescaler and tap selection
  // ----------------------------------------
  // Free-running: a restart does not realign the tick, so the
  // first period after a restart may be up to one tick short.
  logic [11:0] prescale_q;

  always_ff @(posedge clock) begin
    if (rst) begin
      prescale_q <= '0;
    end else begin
      prescale_q <= prescale_q + 12'h001;
    end
  end

  // One-cycle tick enables at each divide ratio
  wire tick32 = &prescale_q[4:0];
  wire tick128 = &prescale_q[6:0];
  wire tick1024 = &prescale_q[9:0];
  wire tick4096 = &prescale_q[11:0];

  // Tap mux on the select field
  wire tick = (clkSel_q == 2'h0) ? tick32 :
    (clkSel_q == 2'h1) ? tick128 :
    (clkSel_q == 2'h2) ? tick1024 : tick4096;

  // ----------------------------------------
  // Down counter
  // ----------------------------------------
  logic [15:0] count_q;

  // Preload: programmed high nibble over all-ones low bits
  wire [15:0] preload = {preloadHigh_q, kwd_pkg::PRELOAD_LOW};

  // Overflow: enabled tick while at zero; restart wins
  wire ovfEvent = wdEnable && tick &&
    (count_q == 16'h0000) && !restart;

  // Counter: restart reloads, enabled tick decrements
  always_ff @(posedge clock) begin
    if (rst) begin
      count_q <= 16'hFFFF;
    end else if (restart) begin
      count_q <= preload;
    end else if (wdEnable && tick) begin
      count_q <= count_q - 16'h0001;
    end
  end

  // ----------------------------------------
  // Overflow status flag
  // ----------------------------------------
  logic ovfFlag_q; // overflow_flag

  // Restart wins; ovfEvent is already blocked during a restart
  always_ff @(posedge clock) begin
    if (rst) begin
      ovfFlag_q <= 1'b0;
    end else if (ovfEvent) begin
      ovfFlag_q <= 1'b1;
    end else if (restart) begin
      ovfFlag_q <= 1'b0;
    end
  end

  // ----------------------------------------
  // Overflow outputs
  // ----------------------------------------
  logic intReset_q; // Internal reset pulse
  logic irqLine_q; // Interrupt line pulse
  logic [3:0] pinCnt_q; // Remaining low cycles
  logic pinN_q; // Registered pin level

  // Pulse length counter next value
  wire pinStart = ovfEvent && pinEnable;
  wire [3:0] pinCnt_d = pinStart ? kwd_pkg::PIN_LOW_CYCLES :
    (pinCnt_q != 4'h0) ? pinCnt_q - 4'h1 : 4'h0;

  // Single-cycle pulses; ovfEvent already needs enable
  always_ff @(posedge clock) begin
    if (rst) begin
      intReset_q <= 1'b0;
      irqLine_q <= 1'b0;
    end else begin
      intReset_q <= ovfEvent && rstEnable;
      irqLine_q <= ovfEvent && irqEnable;
    end
  end

  // Pin low while the count runs, eight cycles
  always_ff @(posedge clock) begin
    if (rst) begin
      pinCnt_q <= 4'h0;
      pinN_q <= 1'b1;
    end else begin
      pinCnt_q <= pinCnt_d;
      pinN_q <= pinCnt_d == 4'h0;
    end
  end

  assign ovfOut.intReset = intReset_q;
  assign ovfOut.irqLine = irqLine_q;
  assign ovfOut.pinN = pinN_q;

  // ----------------------------------------
  // Event status and mask
  // ----------------------------------------
  logic [1:0] evt_q; // Sticky events, write one to clear
  logic [1:0] mask_q; // Event mask

  // Event sources in status layout
  wire [1:0] evtSet = {keyReject, ovfEvent};
  wire [1:0] evtClr = wrEvent ? busReq.wdata[1:0] : 2'h0;

  // Set wins over a same-cycle clear
  wire [1:0] evt_d = (evt_q & ~evtClr) | evtSet;

  always_ff @(posedge clock) begin
    if (rst) begin
      evt_q <= kwd_pkg::EVT_RST;
      mask_q <= kwd_pkg::MASK_RST;
    end else begin
      evt_q <= evt_d;
      if (wrMask) begin
        mask_q <= busReq.wdata[1:0];
      end
    end
  end

  // Level interrupt from flops only
  assign irq = |(evt_q & mask_q);

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  // Key fields and reserved bits read as zero
  wire [31:0] rdMode = {28'h0000000, mode_q};
  wire [31:0] rdClk = {26'h0000000, preloadHigh_q, clkSel_q};
  wire [31:0] rdStatus = {31'h00000000, ovfFlag_q};
  wire [31:0] rdEvent = {30'h00000000, evt_q};
  wire [31:0] rdMask = {30'h00000000, mask_q};

  // Write-only and unmapped addresses read zero
  wire [31:0] rdMux = hitMode ? rdMode :
    hitClk ? rdClk :
    hitStatus ? rdStatus :
    hitEvent ? rdEvent :
    hitMask ? rdMask : 32'h00000000;

  logic [31:0] rdData_q;

  // Data valid only in the cycle after the strobe
  always_ff @(posedge clock) begin
    if (rst) begin
      rdData_q <= 32'h00000000;
    end else if (busReq.rd) begin
      rdData_q <= rdMux;
    end else begin
      rdData_q <= 32'h00000000;
    end
  end

  assign rdData = rdData_q;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  // Disabled with no pulse in flight: reset pulse, interrupt pulse and pin all quiet next cycle
  property p_quiet_disabled;
    !wdEnable && (pinCnt_q == 4'h0) |=> !intReset_q && !irqLine_q && pinN_q;
  endproperty
  a_quiet_disabled: assert property (p_quiet_disabled)
    else $error("overflow while watchdog disabled");

  // Reset pulse follows overflow exactly when enabled
  property p_reset_pulse;
    intReset_q == $past(ovfEvent && rstEnable);
  endproperty
  a_reset_pulse: assert property (p_reset_pulse)
    else $error("internal reset does not match overflow");

  // Interrupt is one cycle wide and caused by overflow
  property p_irq_single;
    irqLine_q |-> $past(ovfEvent && irqEnable) ##1 !irqLine_q;
  endproperty
  a_irq_single: assert property (p_irq_single)
    else $error("interrupt pulse wrong");

  // Pin goes low the cycle after an enabled overflow
  property p_pin_start;
    ovfEvent && pinEnable |=> !pinN_q;
  endproperty
  a_pin_start: assert property (p_pin_start)
    else $error("pin did not fall on overflow");

  // Pin low exactly eight cycles
  property p_pin_len;
    $fell(pinN_q) |-> !pinN_q[*8] ##1 pinN_q;
  endproperty
  a_pin_len: assert property (p_pin_len)
    else $error("pin low width not eight cycles");

  // Wrong mode key leaves the register untouched
  property p_mode_key;
    wrMode && !modeKeyOk |=> mode_q == $past(mode_q);
  endproperty
  a_mode_key: assert property (p_mode_key)
    else $error("mode changed without key");

  // Wrong clock key leaves the register untouched
  property p_clk_key;
    wrClk && !clkKeyOk |=> $stable(preloadHigh_q) && $stable(clkSel_q);
  endproperty
  a_clk_key: assert property (p_clk_key)
    else $error("clock mode changed without key");

  // Restart loads the preload and clears the flag
  property p_restart_load;
    restart |=> count_q == {$past(preloadHigh_q), 12'hFFF} && !ovfFlag_q;
  endproperty
  a_restart_load: assert property (p_restart_load)
    else $error("restart preload wrong");

  // Overflow sets the flag, which then holds
  property p_flag_hold;
    ovfEvent ##1 !restart |=> ovfFlag_q;
  endproperty
  a_flag_hold: assert property (p_flag_hold)
    else $error("overflow flag lost");

  // Counter moves only on restart or an enabled tick
  property p_count_step;
    !restart && !(wdEnable && tick) |=> $stable(count_q);
  endproperty
  a_count_step: assert property (p_count_step)
    else $error("counter moved without tick");

endmodule // kwd_keyed_watchdog

/* File: dv/kwd_keyed_watchdog_tb.sv */
// Self-checking testbench for the keyed watchdog timer
`timescale 1ns/1ps
module kwd_keyed_watchdog_tb;

  // ----------------------------------------
  // Signals and counters
  // ----------------------------------------
  localparam int TIMEOUT_CYCLES = 200000; // One overflow alone needs about 131k cycles
  logic clock; // 10 MHz master clock
  logic rst; // Synchronous reset, active high
  kwd_pkg::kwd_bus_req_t busReq; // Register bus request
  logic [31:0] rdData; // Read data, one cycle after the strobe
  kwd_pkg::kwd_ovf_out_t ovfOut; // Overflow reset, interrupt and pin
  logic irq; // Level interrupt from event status
  int badCount; // Mismatches seen
  int checksDone; // Comparisons made
  int cycleCount; // Cycles since time zero

  kwd_keyed_watchdog u_dut (
    .clock(clock),
    .rst(rst),
    .busReq(busReq),
    .rdData(rdData),
    .ovfOut(ovfOut),
    .irq(irq)
  );

  // ----------------------------------------
  // Clock and hang guard
  // ----------------------------------------
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  // Cuts a hang short; the overflow wait is the long pole
  always @(posedge clock) begin
    cycleCount++;
    if (cycleCount == TIMEOUT_CYCLES) begin
      badCount++;
      completeRun();
    end
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  // Compare and report at once
  task automatic check(input logic [31:0] seen, input logic [31:0] expd);
    checksDone++;
    if (seen !== expd) begin
      badCount++;
      $display("BAD t=%0t seen=%h expected=%h", $time, seen, expd);
    end
  endtask

  // One-cycle write strobe
  task automatic busWrite(input logic [7:0] addr, input logic [31:0] data);
    @(posedge clock);
    busReq.addr <= addr;
    busReq.wdata <= data;
    busReq.wr <= 1'b1;
    @(posedge clock);
    busReq.wr <= 1'b0;
  endtask

  // One-cycle read strobe; data only stands in the following cycle
  task automatic busRead(input logic [7:0] addr, input logic [31:0] expd);
    @(posedge clock);
    busReq.addr <= addr;
    busReq.rd <= 1'b1;
    @(posedge clock);
    busReq.rd <= 1'b0;
    @(negedge clock);
    check(rdData, expd);
  endtask

  // Verdict and end of run
  task automatic completeRun();
    $display("checks=%0d mismatches=%0d", checksDone, badCount);
    if (badCount == 0 && checksDone > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  // Register values straight out of reset, plus holes in the map
  task automatic testResetValues();
    busRead(kwd_pkg::OFS_MODE, 32'h0000_0000);
    busRead(kwd_pkg::OFS_CLK, 32'h0000_0000);
    busRead(kwd_pkg::OFS_STATUS, 32'h0000_0000);
    busRead(kwd_pkg::OFS_RESTART, 32'h0000_0000);
    busRead(kwd_pkg::OFS_EVENT, 32'h0000_0000);
    busRead(kwd_pkg::OFS_MASK, 32'h0000_0000);
    busRead(8'h18, 32'h0000_0000);
  endtask

  // Wrong keys, split keys, every clock select, then the documented sequence
  task automatic testKeys();
    busWrite(kwd_pkg::OFS_MODE, 32'h0000_2355);
    busRead(kwd_pkg::OFS_MODE, 32'h0000_0000);
    busWrite(kwd_pkg::OFS_CLK, 32'h0000_3F3D);
    busRead(kwd_pkg::OFS_CLK, 32'h0000_0000);
    busRead(kwd_pkg::OFS_EVENT, 32'h0000_0002);
    busWrite(kwd_pkg::OFS_MASK, 32'h0000_0002);
    @(negedge clock);
    check({31'h0, irq}, 32'h1);
    busWrite(kwd_pkg::OFS_EVENT, 32'h0000_0002);
    @(negedge clock);
    check({31'h0, irq}, 32'h0);
    busWrite(kwd_pkg::OFS_MASK, 32'h0000_0000);
    // Key alone, then bits alone: must not unlock
    busWrite(kwd_pkg::OFS_MODE, 32'h0000_2340);
    busWrite(kwd_pkg::OFS_MODE, 32'h0000_000F);
    busRead(kwd_pkg::OFS_MODE, 32'h0000_0000);
    for (int s = 0; s < 4; s++) begin
      busWrite(kwd_pkg::OFS_CLK, 32'h0000_3700 | s);
      busRead(kwd_pkg::OFS_CLK, s);
    end
    busWrite(kwd_pkg::OFS_CLK, 32'h0000_373C);
    busRead(kwd_pkg::OFS_CLK, 32'h0000_003C);
    busWrite(kwd_pkg::OFS_RESTART, 32'h0000_C071);
    busWrite(kwd_pkg::OFS_MODE, 32'h0000_2345);
    busRead(kwd_pkg::OFS_MODE, 32'h0000_0005);
    busWrite(kwd_pkg::OFS_MODE, 32'h0000_2340);
    busRead(kwd_pkg::OFS_MODE, 32'h0000_0000);
  endtask

  // One full overflow from preload 0x0FFF at divide by 32
  task automatic testOverflow();
    time t0;
    int elapsed;
    int lows;
    busWrite(kwd_pkg::OFS_CLK, 32'h0000_3700);
    busWrite(kwd_pkg::OFS_RESTART, 32'h0000_C071);
    busWrite(kwd_pkg::OFS_MODE, 32'h0000_234F);
    t0 = $time;
    // Late near-miss key: a wrongful reload would push the overflow far out
    repeat (128000) @(posedge clock);
    busWrite(kwd_pkg::OFS_RESTART, 32'h0000_C070);
    while (ovfOut.irqLine !== 1'b1 && ($time - t0) < 64'd14000000) begin
      @(negedge clock);
    end
    elapsed = int'(($time - t0) / 100);
    check({31'h0, (elapsed >= 4095 * 32) && (elapsed <= 4097 * 32 + 4)}, 32'h1);
    check({29'h0, ovfOut}, 32'h6);
    @(negedge clock);
    check({30'h0, ovfOut.intReset, ovfOut.irqLine}, 32'h0);
    lows = 1;
    while (ovfOut.pinN === 1'b0 && lows < 20) begin
      lows++;
      @(negedge clock);
    end
    check(lows, 32'h8);
    busRead(kwd_pkg::OFS_STATUS, 32'h0000_0001);
    // Bit 1 still holds the split-key rejection from the key scenario
    busRead(kwd_pkg::OFS_EVENT, 32'h0000_0003);
    check({31'h0, irq}, 32'h0);
    busWrite(kwd_pkg::OFS_MASK, 32'h0000_0001);
    @(negedge clock);
    check({31'h0, irq}, 32'h1);
    busWrite(kwd_pkg::OFS_EVENT, 32'h0000_0001);
    @(negedge clock);
    check({31'h0, irq}, 32'h0);
    busWrite(kwd_pkg::OFS_RESTART, 32'h0000_C071);
    busRead(kwd_pkg::OFS_STATUS, 32'h0000_0000);
  endtask

  // Reset in mid-run clears everything back to disabled
  task automatic testSecondReset();
    busWrite(kwd_pkg::OFS_CLK, 32'h0000_373F);
    busWrite(kwd_pkg::OFS_MASK, 32'h0000_0003);
    @(negedge clock);
    check({31'h0, irq}, 32'h1);
    @(posedge clock);
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    busRead(kwd_pkg::OFS_MODE, 32'h0000_0000);
    busRead(kwd_pkg::OFS_CLK, 32'h0000_0000);
    busRead(kwd_pkg::OFS_MASK, 32'h0000_0000);
    busRead(kwd_pkg::OFS_EVENT, 32'h0000_0000);
    check({31'h0, irq}, 32'h0);
    check({29'h0, ovfOut}, 32'h1);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    rst = 1'b1;
    busReq = '0;
    badCount = 0;
    checksDone = 0;
    cycleCount = 0;
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    testResetValues();
    testKeys();
    testOverflow();
    testSecondReset();
    completeRun();
  end

endmodule // kwd_keyed_watchdog_tb
